// file: shared/halt_wake_pkg.sv
/*
  Constants, register layout, carriers and state codes for the halt,
  wake-up and reset sequencer.
  Assumes a 20 MHz system clock and a 32-bit AHB-Lite register bus.
*/
`default_nettype none
package halt_wake_pkg;
  // start-up delay after every reset and wake-up, in system clocks
  localparam int unsigned STARTUP_CYCLES = 1024;
  localparam int unsigned CLK_PERIOD_NS  = 50;
  // watchdog base divider is 2**8; prescaler adds up to 2**7
  localparam int unsigned WDT_CNT_W      = 16;
  localparam logic [15:0] WDT_BASE       = 16'h0100;
  localparam logic [15:0] WDT_ONE        = 16'h0001;
  localparam logic [1:0]  INSTR_DIV_LAST = 2'h3;
  // register byte addresses
  localparam logic [31:0] CTRL_OFFSET    = 32'h0000_0000;
  localparam logic [31:0] STATUS_OFFSET  = 32'h0000_0004;
  // control field positions
  localparam int unsigned CTRL_MASK_LSB  = 0;
  localparam int unsigned CTRL_TWICE_BIT = 8;
  localparam int unsigned CTRL_WDTEN_BIT = 9;
  localparam int unsigned CTRL_RATIO_LSB = 10;
  localparam int unsigned CTRL_SRC_BIT   = 13;
  localparam int unsigned CTRL_W         = 14;
  localparam logic [13:0] CTRL_RESET     = 14'h1E00;
  // status field positions
  localparam int unsigned STAT_TO_BIT    = 0;
  localparam int unsigned STAT_PDF_BIT   = 1;
  localparam int unsigned STAT_STATE_LSB = 2;
  localparam int unsigned STAT_W         = 5;
  localparam logic [1:0]  HTRANS_NONSEQ  = 2'h2;
  localparam logic [31:0] ZERO_WORD      = 32'h0000_0000;

  // layout equals the control register bits 13..0
  typedef struct packed {
    logic       src_instr;
    logic [2:0] ratio;
    logic       wdt_en;
    logic       clr_twice;
    logic [7:0] pa_mask;
  } ctrl_type;

  typedef enum logic [2:0] {
    ST_HOLD  = 3'b000,
    ST_DELAY = 3'b001,
    ST_RUN   = 3'b010,
    ST_HALT  = 3'b011,
    ST_VEC   = 3'b100
  } seq_state_type;

  typedef enum logic [1:0] {
    DLY_CHIP = 2'b00,
    DLY_WARM = 2'b01,
    DLY_NEXT = 2'b10,
    DLY_VEC  = 2'b11
  } dly_kind_type;

  typedef struct packed {
    logic [2:0] state;
    logic       powerdown_flag;
    logic       to;
  } status_type;
endpackage
`default_nettype wire

// file: core/halt_wake_reset_sequencer.sv
/*
  Halt, wake-up and reset sequencer of a small microcontroller, with its
  watchdog counter, reset-cause flags and an AHB-Lite register slave.
  Assumes the core reports halt and watchdog-clear instructions as
  one-cycle pulses and obeys core_reset_o, warm_reset_o and core_run_o;
  port pins, the reset pin and the watchdog oscillator are asynchronous.

  // How it works
  // - halt stops the system oscillator; watchdog oscillator keeps running
  // - memory and registers are retained unchanged during power-down
  // - halt entry clears watchdog and prescaler when on its own oscillator
  // - port pins hold their state throughout power-down
  // - halt sets powerdown flag, clears timeout; clear instruction clears it
  // - wake on external reset, interrupt, port A fall, watchdog overflow
  // - watchdog overflow in halt sets timeout and does a warm reset
  // - each port A pin is separately enabled as a wake source
  // - port wake resumes at the instruction after halt
  // - interrupt wake vectors only if enabled and stack not full
  // - an interrupt already pending at halt entry cannot wake
  // - every wake-up inserts 1024 system clocks before resuming
  // - vectored wake adds one more cycle; plain resume does not
  // - start-up delay of 1024 clocks on every reset and wake-up
  // - reset sources: pin in run, pin in halt, watchdog, bus reset
  // - timeout and powerdown flags encode the reset cause
  // - chip reset zeroes PC, disables interrupts, restarts watchdog
  // - chip resets reinitialise state; warm reset touches only PC and SP
  // - clear instruction clears watchdog; two-step option needs both
*/
`timescale 1ns/1ps
`default_nettype none
module halt_wake_reset_sequencer #(
  parameter int unsigned STARTUP_N = halt_wake_pkg::STARTUP_CYCLES,
  parameter int unsigned IRQ_N     = 6,
  parameter int unsigned PA_W      = 8
) (
  // clock and reset
  input  wire logic              ref_clk_i,
  input  wire logic              resetn_i,
  // AHB-Lite slave
  input  wire logic              hsel_i,
  input  wire logic [31:0]       haddr_i,
  input  wire logic [1:0]        htrans_i,
  input  wire logic              hwrite_i,
  input  wire logic [2:0]        hsize_i,
  input  wire logic [31:0]       hwdata_i,
  input  wire logic              hready_i,
  output logic      [31:0]       hrdata_o,
  output logic                   hreadyout_o,
  output logic                   hresp_o,
  // asynchronous pins
  input  wire logic              external_reset_pin_n_i,
  input  wire logic [PA_W-1:0]   pa_pins_i,
  input  wire logic              wdt_osc_i,
  // core events, same clock
  input  wire logic              halt_exec_i,
  input  wire logic              watchdog_clear_instruction_i,
  input  wire logic              wdt_clear1_i,
  input  wire logic              wdt_clear2_i,
  input  wire logic              usb_bus_reset_i,
  input  wire logic [IRQ_N-1:0]  irq_req_i,
  input  wire logic              irq_enable_i,
  input  wire logic              stack_full_i,
  // sequencing outputs
  output logic                   sys_osc_en_o,
  output logic                   retain_o,
  output logic                   port_hold_o,
  output logic                   core_reset_o,
  output logic                   warm_reset_o,
  output logic                   core_run_o,
  output logic                   resume_next_o,
  output logic                   resume_vector_o,
  output logic                   timeout_flag_o,
  output logic                   powerdown_flag_o
);
  localparam int unsigned CNT_W = $clog2(STARTUP_N);
  localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(STARTUP_N - 1);

  generate
    if (STARTUP_N < 2 || IRQ_N < 1 || PA_W < 1 || PA_W > 8) begin : g_bad
      $error("sequencer parameters out of range");
    end
  endgenerate

  halt_wake_pkg::ctrl_type      ctrl_r;
  halt_wake_pkg::seq_state_type state_r;
  halt_wake_pkg::seq_state_type state_nxt;
  halt_wake_pkg::dly_kind_type  kind_r;
  halt_wake_pkg::dly_kind_type  kind_nxt;
  logic [CNT_W-1:0]             dly_cnt_r;
  logic [15:0]                  wdt_cnt_r;
  logic [15:0]                  wdt_lim;
  logic [1:0]                   div_r;
  logic                         clr1_seen_r;
  logic                         clr2_seen_r;
  logic [IRQ_N-1:0]             armed_r;
  logic                         to_r;
  logic                         pdf_r;
  logic                         ext_s1_r;
  logic                         ext_s2_r;
  logic                         osc_s1_r;
  logic                         osc_s2_r;
  logic                         osc_s3_r;
  logic [PA_W-1:0]              pa_s1_r;
  logic [PA_W-1:0]              pa_s2_r;
  logic [PA_W-1:0]              pa_s3_r;
  logic                         wdt_tick;
  logic                         wdt_ovf;
  logic                         wdt_clr_ok;
  logic                         pa_wake;
  logic                         irq_wake;
  logic                         dly_done;
  logic                         halt_entry;
  logic                         rst_req;
  logic                         bus_take;
  logic                         wr_pend_r;
  logic [31:0]                  wr_addr_r;
  halt_wake_pkg::status_type    status;

  // two-flop synchronisers; edge detection compares the second stage with a third
  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      ext_s1_r <= 1'b1;
      ext_s2_r <= 1'b1;
      osc_s1_r <= 1'b0;
      osc_s2_r <= 1'b0;
      osc_s3_r <= 1'b0;
      pa_s1_r  <= '1;
      pa_s2_r  <= '1;
      pa_s3_r  <= '1;
    end else begin
      ext_s1_r <= external_reset_pin_n_i;
      ext_s2_r <= ext_s1_r;
      osc_s1_r <= wdt_osc_i;
      osc_s2_r <= osc_s1_r;
      osc_s3_r <= osc_s2_r;
      pa_s1_r  <= pa_pins_i;
      pa_s2_r  <= pa_s1_r;
      pa_s3_r  <= pa_s2_r;
    end
  end

  assign halt_entry = (state_r == halt_wake_pkg::ST_RUN) && halt_exec_i;
  assign rst_req    = !ext_s2_r || usb_bus_reset_i;
  assign pa_wake    = |(pa_s3_r & ~pa_s2_r & ctrl_r.pa_mask[PA_W-1:0]);
  assign irq_wake   = |(irq_req_i & armed_r);
  assign dly_done   = (dly_cnt_r == CNT_LAST);

  // watchdog tick: own oscillator runs always; instruction clock is
  // stopped by halt, so that source loses protection while halted
  assign wdt_tick = ctrl_r.src_instr
                  ? (div_r == halt_wake_pkg::INSTR_DIV_LAST) &&
                    (state_r != halt_wake_pkg::ST_HALT)
                  : (osc_s2_r && !osc_s3_r);
  assign wdt_lim  = 16'((halt_wake_pkg::WDT_BASE << ctrl_r.ratio)
                        - halt_wake_pkg::WDT_ONE);
  assign wdt_ovf  = ctrl_r.wdt_en && wdt_tick && (wdt_cnt_r == wdt_lim) &&
                    ((state_r == halt_wake_pkg::ST_RUN) ||
                     (state_r == halt_wake_pkg::ST_HALT));
  assign wdt_clr_ok = ctrl_r.clr_twice
                    ? ((clr1_seen_r || wdt_clear1_i) &&
                       (clr2_seen_r || wdt_clear2_i))
                    : watchdog_clear_instruction_i;

  always_comb begin
    state_nxt = state_r;
    kind_nxt  = kind_r;
    if (rst_req) begin
      state_nxt = halt_wake_pkg::ST_HOLD;
      kind_nxt  = halt_wake_pkg::DLY_CHIP;
    end else begin
      unique case (state_r)
        halt_wake_pkg::ST_HOLD: begin
          state_nxt = halt_wake_pkg::ST_DELAY;
        end
        halt_wake_pkg::ST_DELAY: begin
          if (dly_done) begin
            state_nxt = (kind_r == halt_wake_pkg::DLY_VEC)
                      ? halt_wake_pkg::ST_VEC
                      : halt_wake_pkg::ST_RUN;
          end
        end
        halt_wake_pkg::ST_RUN: begin
          if (wdt_ovf) begin
            state_nxt = halt_wake_pkg::ST_DELAY;
            kind_nxt  = halt_wake_pkg::DLY_CHIP;
          end else if (halt_exec_i) begin
            state_nxt = halt_wake_pkg::ST_HALT;
          end
        end
        halt_wake_pkg::ST_HALT: begin
          if (wdt_ovf) begin
            state_nxt = halt_wake_pkg::ST_DELAY;
            kind_nxt  = halt_wake_pkg::DLY_WARM;
          end else if (irq_wake) begin
            state_nxt = halt_wake_pkg::ST_DELAY;
            kind_nxt  = (irq_enable_i && !stack_full_i)
                      ? halt_wake_pkg::DLY_VEC
                      : halt_wake_pkg::DLY_NEXT;
          end else if (pa_wake) begin
            state_nxt = halt_wake_pkg::ST_DELAY;
            kind_nxt  = halt_wake_pkg::DLY_NEXT;
          end
        end
        halt_wake_pkg::ST_VEC: begin
          state_nxt = halt_wake_pkg::ST_RUN;
        end
        default: begin
          state_nxt = halt_wake_pkg::ST_HOLD;
        end
      endcase
    end
  end

  // power-up starts straight into a chip-type start-up delay
  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      state_r <= halt_wake_pkg::ST_DELAY;
      kind_r  <= halt_wake_pkg::DLY_CHIP;
    end else begin
      state_r <= state_nxt;
      kind_r  <= kind_nxt;
    end
  end

  // counts restarted system clocks; restarts on every delay entry
  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      dly_cnt_r <= '0;
    end else if (state_r != halt_wake_pkg::ST_DELAY ||
                 state_nxt != halt_wake_pkg::ST_DELAY) begin
      dly_cnt_r <= '0;
    end else begin
      dly_cnt_r <= dly_cnt_r + 1'b1;
    end
  end

  // interrupts already pending at halt entry are not armed
  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      armed_r <= '0;
    end else if (halt_entry) begin
      armed_r <= ~irq_req_i;
    end
  end

  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      div_r <= '0;
    end else begin
      div_r <= div_r + 1'b1;
    end
  end

  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      clr1_seen_r <= 1'b0;
      clr2_seen_r <= 1'b0;
    end else if (wdt_clr_ok || state_r != halt_wake_pkg::ST_RUN) begin
      clr1_seen_r <= 1'b0;
      clr2_seen_r <= 1'b0;
    end else begin
      clr1_seen_r <= clr1_seen_r || wdt_clear1_i;
      clr2_seen_r <= clr2_seen_r || wdt_clear2_i;
    end
  end

  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      wdt_cnt_r <= '0;
    end else if (rst_req || state_r == halt_wake_pkg::ST_HOLD) begin
      wdt_cnt_r <= '0;
    end else if (halt_entry && !ctrl_r.src_instr) begin
      wdt_cnt_r <= '0;
    end else if (state_r == halt_wake_pkg::ST_RUN && wdt_clr_ok) begin
      wdt_cnt_r <= '0;
    end else if (wdt_ovf) begin
      wdt_cnt_r <= '0;
    end else if (wdt_tick && ctrl_r.wdt_en) begin
      wdt_cnt_r <= wdt_cnt_r + 1'b1;
    end
  end

  // reset-cause flags; halt entry wins over a clear in the same cycle
  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      to_r  <= 1'b0;
      pdf_r <= 1'b0;
    end else if (rst_req && state_r == halt_wake_pkg::ST_HALT) begin
      to_r  <= 1'b0;
      pdf_r <= 1'b1;
    end else if (rst_req) begin
      to_r  <= to_r;
      pdf_r <= pdf_r;
    end else if (wdt_ovf) begin
      to_r  <= 1'b1;
      pdf_r <= (state_r == halt_wake_pkg::ST_HALT) ? 1'b1 : pdf_r;
    end else if (halt_entry) begin
      to_r  <= 1'b0;
      pdf_r <= 1'b1;
    end else if (state_r == halt_wake_pkg::ST_RUN && wdt_clr_ok) begin
      pdf_r <= 1'b0;
    end
  end

  // outputs except the two flags follow the next state so they change with it; the flag outputs copy to_r and pdf_r a cycle late
  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      sys_osc_en_o     <= 1'b1;
      retain_o         <= 1'b0;
      port_hold_o      <= 1'b0;
      core_reset_o     <= 1'b1;
      warm_reset_o     <= 1'b0;
      core_run_o       <= 1'b0;
      resume_next_o    <= 1'b0;
      resume_vector_o  <= 1'b0;
      timeout_flag_o   <= 1'b0;
      powerdown_flag_o <= 1'b0;
    end else begin
      sys_osc_en_o  <= (state_nxt != halt_wake_pkg::ST_HALT);
      // wake and warm delays keep memory and registers; port pins are held only in halt
      retain_o      <= (state_nxt == halt_wake_pkg::ST_HALT) ||
                       (state_nxt == halt_wake_pkg::ST_DELAY &&
                        kind_nxt != halt_wake_pkg::DLY_CHIP);
      port_hold_o   <= (state_nxt == halt_wake_pkg::ST_HALT);
      core_reset_o  <= (state_nxt == halt_wake_pkg::ST_HOLD) ||
                       (state_nxt == halt_wake_pkg::ST_DELAY &&
                        kind_nxt == halt_wake_pkg::DLY_CHIP);
      warm_reset_o  <= (state_nxt == halt_wake_pkg::ST_DELAY &&
                        kind_nxt == halt_wake_pkg::DLY_WARM);
      core_run_o    <= (state_nxt == halt_wake_pkg::ST_RUN);
      resume_next_o <= (state_r == halt_wake_pkg::ST_DELAY) && dly_done &&
                       !rst_req && (kind_r == halt_wake_pkg::DLY_NEXT);
      resume_vector_o  <= (state_r == halt_wake_pkg::ST_VEC) &&
                          !rst_req;
      timeout_flag_o   <= to_r;
      powerdown_flag_o <= pdf_r;
    end
  end

  // AHB-Lite slave: zero wait states, always OKAY
  assign bus_take = hsel_i && hready_i && htrans_i[1];
  assign status   = '{state: state_r, powerdown_flag: pdf_r, to: to_r};

  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      wr_pend_r   <= 1'b0;
      wr_addr_r   <= '0;
      hrdata_o    <= '0;
      hreadyout_o <= 1'b1;
      hresp_o     <= 1'b0;
    end else begin
      wr_pend_r   <= bus_take && hwrite_i;
      wr_addr_r   <= bus_take ? haddr_i : wr_addr_r;
      hreadyout_o <= 1'b1;
      hresp_o     <= 1'b0;
      if (bus_take && !hwrite_i && haddr_i == halt_wake_pkg::CTRL_OFFSET) begin
        hrdata_o <= {18'h0_0000, ctrl_r};
      end else if (bus_take && !hwrite_i &&
                   haddr_i == halt_wake_pkg::STATUS_OFFSET) begin
        hrdata_o <= {27'h000_0000, status};
      end else begin
        hrdata_o <= halt_wake_pkg::ZERO_WORD;
      end
    end
  end

  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      ctrl_r <= halt_wake_pkg::CTRL_RESET;
    end else if (wr_pend_r && wr_addr_r == halt_wake_pkg::CTRL_OFFSET) begin
      ctrl_r <= hwdata_i[halt_wake_pkg::CTRL_W-1:0];
    end
  end

  // helper: length of the current delay, seen only by checks
  logic [15:0] chk_len_r;
  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      chk_len_r <= '0;
    end else if (state_r == halt_wake_pkg::ST_DELAY) begin
      chk_len_r <= chk_len_r + 1'b1;
    end else begin
      chk_len_r <= '0;
    end
  end

  chk_osc_stopped: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
    state_r == halt_wake_pkg::ST_HALT |-> !sys_osc_en_o && port_hold_o)
    else $error("oscillator or port hold wrong while halted");

  chk_halt_flags: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
    halt_entry && !rst_req && !wdt_ovf |=> ##1 powerdown_flag_o && !timeout_flag_o)
    else $error("halt entry did not set flags");

  chk_wdt_restart: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
    halt_entry && !rst_req && !ctrl_r.src_instr |=> wdt_cnt_r == 16'h0000)
    else $error("watchdog not cleared on halt entry");

  chk_delay_length: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
    state_r == halt_wake_pkg::ST_DELAY && !rst_req &&
    state_nxt != halt_wake_pkg::ST_DELAY |-> chk_len_r == 16'(STARTUP_N - 1))
    else $error("start-up delay has wrong length");

  chk_vector_extra: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
    resume_vector_o |-> $past(state_r, 2) == halt_wake_pkg::ST_DELAY &&
                        $past(kind_r, 2) == halt_wake_pkg::DLY_VEC)
    else $error("vectored resume without extra cycle");

  chk_warm_reset: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
    state_r == halt_wake_pkg::ST_HALT && wdt_ovf && !rst_req |=>
    ##1 warm_reset_o && !core_reset_o && timeout_flag_o && powerdown_flag_o)
    else $error("watchdog wake did not warm reset");

  chk_stale_irq: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
    state_r == halt_wake_pkg::ST_HALT && !irq_wake && !pa_wake &&
    !wdt_ovf && !rst_req |=> state_r == halt_wake_pkg::ST_HALT)
    else $error("left halt without a wake event");

  chk_plain_resume: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
    resume_next_o |-> core_run_o && !resume_vector_o)
    else $error("plain resume not immediate");

  chk_bus_okay: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
    hreadyout_o && !hresp_o)
    else $error("bus answer not OKAY and ready");
endmodule // halt_wake_reset_sequencer
`default_nettype wire

// file: verification/test_halt_wake_reset_sequencer.sv
/*
  Self-checking bench for the halt, wake-up and reset sequencer.
  Assumes a short start-up count and that the bench alone plays the
  core, the pins, the watchdog oscillator and the bus master.
*/
`timescale 1ns/1ps
`default_nettype none
module test_halt_wake_reset_sequencer;
  localparam int          N     = 16;
  localparam logic [31:0] ZERO  = 32'h0000_0000;
  localparam logic [31:0] ONE_W = 32'h0000_0001;
  logic        ref_clk_i = 1'b0;
  logic        resetn_i = 1'b0;
  logic        hsel_i = 1'b0, hwrite_i = 1'b0;
  logic [31:0] haddr_i = ZERO, hwdata_i = ZERO;
  logic [1:0]  htrans_i = 2'h0;
  logic [2:0]  hsize_i = 3'h2;
  logic [7:0]  pa_pins_i = 8'hFF;
  logic        external_reset_pin_n_i = 1'b1, wdt_osc_i = 1'b0;
  logic        halt_exec_i = 1'b0, watchdog_clear_instruction_i = 1'b0;
  logic        wdt_clear1_i = 1'b0, wdt_clear2_i = 1'b0;
  logic        usb_bus_reset_i = 1'b0, irq_enable_i = 1'b0;
  logic        stack_full_i = 1'b0, osc_run = 1'b0, osc_div = 1'b0;
  logic [5:0]  irq_req_i = 6'h00;
  logic [31:0] hrdata_o;
  logic        hreadyout_o, hresp_o, sys_osc_en_o, retain_o, port_hold_o;
  logic        core_reset_o, warm_reset_o, core_run_o, resume_next_o;
  logic        resume_vector_o, timeout_flag_o, powerdown_flag_o;
  wire logic   hready_i = hreadyout_o;
  int          bad_count = 0, cmp_count = 0, cyc = 0;
  int          seed = 32'h0e1a_0e1f;

  halt_wake_reset_sequencer #(.STARTUP_N(N)) halt_wake_reset_sequencer_i (
    .ref_clk_i, .resetn_i, .hsel_i, .haddr_i, .htrans_i, .hwrite_i,
    .hsize_i, .hwdata_i, .hready_i, .hrdata_o, .hreadyout_o, .hresp_o,
    .external_reset_pin_n_i, .pa_pins_i, .wdt_osc_i, .halt_exec_i,
    .watchdog_clear_instruction_i, .wdt_clear1_i, .wdt_clear2_i,
    .usb_bus_reset_i, .irq_req_i, .irq_enable_i, .stack_full_i,
    .sys_osc_en_o, .retain_o, .port_hold_o, .core_reset_o, .warm_reset_o,
    .core_run_o, .resume_next_o, .resume_vector_o, .timeout_flag_o,
    .powerdown_flag_o
  );

  always #25 ref_clk_i = ~ref_clk_i;

  task automatic close_out();
    if (bad_count == 0 && cmp_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // oscillator period of four clocks: 256 ticks take 1024 clocks
  always @(posedge ref_clk_i) begin
    cyc <= cyc + 1;
    if (osc_run) begin
      osc_div <= ~osc_div;
      if (osc_div) wdt_osc_i <= ~wdt_osc_i;
    end
    if (cyc == 20000) begin
      bad_count++;
      close_out();
    end
  end

  function automatic logic [31:0] inr(int n, int lo, int hi);
    return {31'h0000_0000, (n >= lo && n <= hi)};
  endfunction

  function automatic logic [31:0] fl();
    return {30'h0000_0000, powerdown_flag_o, timeout_flag_o};
  endfunction

  function automatic logic sig(int s);
    return s == 0 ? core_run_o : (s == 1 ? warm_reset_o : core_reset_o);
  endfunction

  task automatic await(input int s, output int n);
    n = 0;
    while (sig(s) !== 1'b1 && n < 3000) begin
      @(posedge ref_clk_i);
      n++;
    end
  endtask

  task automatic run_wait(input int lo, input int hi);
    int n;
    await(0, n);
    chk(inr(n, lo, hi), ONE_W);
  endtask

  task automatic bus(input logic w, input logic [31:0] a, d,
                     output logic [31:0] r);
    hsel_i <= 1'b1;
    htrans_i <= halt_wake_pkg::HTRANS_NONSEQ;
    haddr_i <= a;
    hwrite_i <= w;
    do @(posedge ref_clk_i); while (hready_i !== 1'b1);
    hsel_i <= 1'b0;
    htrans_i <= 2'h0;
    hwdata_i <= d;
    do @(posedge ref_clk_i); while (hready_i !== 1'b1);
    r = hrdata_o;
    chk(32'({hreadyout_o, hresp_o}), 32'h0000_0002);
  endtask

  task automatic halt_it();
    halt_exec_i <= 1'b1;
    @(posedge ref_clk_i);
    halt_exec_i <= 1'b0;
    repeat (3) @(posedge ref_clk_i);
    chk(32'(sys_osc_en_o), ZERO);
    chk(32'(port_hold_o & retain_o), ONE_W);
    chk(fl(), 32'h0000_0002);
  endtask

  initial begin
    logic [31:0] r;
    logic [31:0] d;
    int p;
    int q;
    repeat (10) @(posedge ref_clk_i);
    resetn_i <= 1'b1;
    run_wait(N, N + 4);
    chk(fl(), ZERO);
    bus(1'b0, halt_wake_pkg::CTRL_OFFSET, ZERO, r);
    chk(r, 32'h0000_1E00);
    // watchdog stays disabled here so the oscillator may stand still
    for (int k = 0; k < 3; k++) begin
      d = $random(seed) & 32'h0000_1CFF;
      bus(1'b1, halt_wake_pkg::CTRL_OFFSET, d, r);
      bus(1'b0, halt_wake_pkg::CTRL_OFFSET, ZERO, r);
      chk(r, d);
    end
    for (int k = 0; k < 2; k++) begin
      d = k == 0 ? 32'h0000_0008 : halt_wake_pkg::STATUS_OFFSET;
      bus(1'b1, d, 32'hFFFF_FFFF, r);
      bus(1'b0, d, ZERO, r);
      chk(r, k == 0 ? ZERO : 32'h0000_0008);
    end
    p = $unsigned($random(seed)) % 8;
    q = (p + 1) % 8;
    bus(1'b1, halt_wake_pkg::CTRL_OFFSET, ONE_W << p, r);
    halt_it();
    pa_pins_i[q] <= 1'b0;
    repeat (30) @(posedge ref_clk_i);
    chk(32'(core_run_o), ZERO);
    pa_pins_i <= 8'hFF;
    @(posedge ref_clk_i);
    pa_pins_i[p] <= 1'b0;
    run_wait(N, N + 8);
    chk(32'({resume_next_o, resume_vector_o}), 32'h0000_0002);
    pa_pins_i <= 8'hFF;
    for (int k = 0; k < 3; k++) begin
      irq_enable_i <= (k > 0);
      stack_full_i <= (k == 1);
      irq_req_i <= 6'h01;
      @(posedge ref_clk_i);
      halt_it();
      repeat (30) @(posedge ref_clk_i);
      chk(32'(core_run_o), ZERO);
      irq_req_i <= 6'h03;
      run_wait(N, N + 9);
      chk(32'(resume_vector_o), 32'(k == 2));
      chk(32'(resume_next_o), 32'(k != 2));
      irq_req_i <= 6'h00;
    end
    bus(1'b1, halt_wake_pkg::CTRL_OFFSET, 32'h0000_0200, r);
    osc_run <= 1'b1;
    // 150 ticks counted before halt must not shorten the halt timeout
    repeat (600) @(posedge ref_clk_i);
    halt_it();
    await(1, p);
    chk(inr(p, 950, 1100), ONE_W);
    chk(32'(core_reset_o), ZERO);
    run_wait(N, N + 4);
    chk(fl(), 32'h0000_0003);
    watchdog_clear_instruction_i <= 1'b1;
    @(posedge ref_clk_i);
    watchdog_clear_instruction_i <= 1'b0;
    repeat (3) @(posedge ref_clk_i);
    chk(fl(), ONE_W);
    await(2, p);
    chk(inr(p, 950, 1100), ONE_W);
    osc_run <= 1'b0;
    run_wait(N, N + 6);
    chk(fl(), ONE_W);
    for (int k = 0; k < 4; k++) begin
      if (k < 2) halt_it();
      if (k % 2 == 1) usb_bus_reset_i <= 1'b1;
      else external_reset_pin_n_i <= 1'b0;
      repeat (5) @(posedge ref_clk_i);
      chk(32'(core_reset_o), ONE_W);
      usb_bus_reset_i <= 1'b0;
      external_reset_pin_n_i <= 1'b1;
      run_wait(N, N + 8);
      chk(fl(), 32'h0000_0002);
    end
    // two-step clear: single clear and first step alone leave the flag set
    bus(1'b1, halt_wake_pkg::CTRL_OFFSET, 32'h0000_0100, r);
    watchdog_clear_instruction_i <= 1'b1;
    wdt_clear1_i <= 1'b1;
    @(posedge ref_clk_i);
    watchdog_clear_instruction_i <= 1'b0;
    wdt_clear1_i <= 1'b0;
    repeat (3) @(posedge ref_clk_i);
    chk(fl(), 32'h0000_0002);
    wdt_clear2_i <= 1'b1;
    @(posedge ref_clk_i);
    wdt_clear2_i <= 1'b0;
    repeat (3) @(posedge ref_clk_i);
    chk(fl(), ZERO);
    close_out();
  end
endmodule // test_halt_wake_reset_sequencer
`default_nettype wire
